// *** hdl/suspend_aware_clock_output.sv ***
// suspend sequencing and clock output selection
`default_nettype none
module suspend_aware_clock_output
  import programmable_clock_out_pkg::*;
#(
  parameter int unsigned SUSP_CYCLES = SUSP_CYC,
  parameter int unsigned WAKE_CYCLES = WAKE_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic oscillator_run,
  input wire logic [programmable_clock_out_pkg::DIV_W-1:0] clock_out_divider,
  input wire logic standby_clock_disable,
  input wire logic suspend_request,
  input wire logic device_wakeup_in,
  output logic programmable_clock_out,
  output logic suspend_out,
  output logic pll_running
);
  import programmable_clock_out_pkg::*;
  // the accumulator carries at twice the pll rate, so its toggling wave is the 48 MHz clock
  localparam longint unsigned PLL_HZ = longint'(REF_HZ) * PLL_MULT;
  localparam logic [31:0] STEP_48 = 32'((PLL_HZ * 2 << 32) / CLK_HZ);
  typedef struct packed {
    pwr_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] lz_cnt;
    logic lz_clk;
    logic req_seen;
    logic [1:0] req_sync;
    logic [1:0] wk_sync;
    logic wk_prev;
    logic [DIV_W-1:0] div_cnt;
    logic fast_prev;
    logic out_clk;
    logic susp;
  } st_t;
  st_t s_r;
  st_t s_nxt;
  logic fast_wave;
  logic osc_on;
  logic fast_edge;
  // oscillator and pll only run while awake and enabled
  assign osc_on = oscillator_run && !s_r.susp;
  // 48 MHz is 8 x 6 MHz reference; synthesised from clk by phase step
  clk_ratio_gen #(.ACC_W(32)) u_pll (
    .clk(clk),
    .arst_n(arst_n),
    .run(osc_on),
    .step(STEP_48),
    .wave(fast_wave)
  );
  // both edges of the fast wave count, so a divider of zero passes 48 MHz straight out
  assign fast_edge = fast_wave ^ s_r.fast_prev;
  always_comb begin
    s_nxt = s_r;
    // both pins pass two flops before the state machine reads them
    s_nxt.req_sync = {s_r.req_sync[0], suspend_request};
    s_nxt.wk_sync = {s_r.wk_sync[0], device_wakeup_in};
    s_nxt.wk_prev = s_r.wk_sync[1];
    s_nxt.fast_prev = fast_wave;
    // standby clock runs from clk, independent of the pll
    if (s_r.lz_cnt == CNT_W'(STANDBY_HALF - 1)) begin
      s_nxt.lz_cnt = '0;
      s_nxt.lz_clk = !s_r.lz_clk;
    end else begin
      s_nxt.lz_cnt = s_r.lz_cnt + 1'b1;
    end
    // output half period is (divider+1) fast half periods: 48/(n+1) MHz, 3 MHz at n=15
    if (fast_edge) begin
      if (s_r.div_cnt >= clock_out_divider) begin
        s_nxt.div_cnt = '0;
        s_nxt.out_clk = !s_r.out_clk;
      end else begin
        s_nxt.div_cnt = s_r.div_cnt + 1'b1;
      end
    end
    // a stopped pll leaves the divider in a known phase for the next start
    if (!osc_on) begin
      s_nxt.div_cnt = DIV_RESET;
      s_nxt.out_clk = 1'b0;
    end
    case (s_r.st)
      ST_RUN: begin
        if (s_r.req_sync[1]) begin
          s_nxt.req_seen = 1'b1;
        end
        // request is armed by a one, fires on the following zero
        if (s_r.req_seen && !s_r.req_sync[1]) begin
          s_nxt.req_seen = 1'b0;
          s_nxt.cnt = '0;
          s_nxt.st = ST_SUSP_WAIT;
        end
      end
      ST_SUSP_WAIT: begin
        s_nxt.cnt = s_r.cnt + 1'b1;
        if (s_r.cnt == CNT_W'(SUSP_CYCLES - 1)) begin
          s_nxt.susp = 1'b1;
          s_nxt.st = ST_SUSP;
        end
      end
      ST_SUSP: begin
        if (s_r.wk_sync[1] && !s_r.wk_prev) begin
          s_nxt.cnt = '0;
          s_nxt.st = ST_WAKE_WAIT;
        end
      end
      ST_WAKE_WAIT: begin
        s_nxt.cnt = s_r.cnt + 1'b1;
        if (s_r.cnt == CNT_W'(WAKE_CYCLES - 1)) begin
          s_nxt.susp = 1'b0;
          s_nxt.st = ST_RUN;
        end
      end
      default: begin
        s_nxt.st = ST_RUN;
        s_nxt.susp = 1'b0;
      end
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '{st: ST_RUN, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end
  // in suspend: standby clock, or low when disabled
  assign programmable_clock_out = s_r.susp ? (s_r.lz_clk && !standby_clock_disable)
                                           : s_r.out_clk;
  assign suspend_out = s_r.susp;
  assign pll_running = osc_on;

  // suspend entry: armed by a one, fired by the following zero, then a counted wait
  sequence req_armed_s;
    s_r.st == ST_RUN && s_r.req_seen;
  endsequence
  sequence req_released_s;
    !s_r.req_sync[1];
  endsequence
  sequence susp_wait_done_s;
    s_r.st == ST_SUSP_WAIT && s_r.cnt == CNT_W'(SUSP_CYCLES - 1);
  endsequence
  // suspend exit: a synchronised rising wake edge, then a counted wait
  sequence wake_rise_s;
    s_r.wk_sync[1] && !s_r.wk_prev;
  endsequence
  sequence wake_wait_done_s;
    s_r.st == ST_WAKE_WAIT && s_r.cnt == CNT_W'(WAKE_CYCLES - 1);
  endsequence

  AST_REQ_FIRE: assert property (@(posedge clk) disable iff (!arst_n)
    req_armed_s ##0 req_released_s |=> s_r.st == ST_SUSP_WAIT && s_r.cnt == '0)
    else $error("armed request did not start the suspend wait");
  AST_REQ_SEQ: assert property (@(posedge clk) disable iff (!arst_n)
    (s_r.st == ST_RUN && !s_r.req_seen) |=> s_r.st != ST_SUSP_WAIT)
    else $error("suspend started without one-then-zero");
  AST_REQ_IGNORED: assert property (@(posedge clk) disable iff (!arst_n)
    s_r.st != ST_RUN |-> !s_r.req_seen)
    else $error("request armed outside the run state");
  AST_SUSP_STEP: assert property (@(posedge clk) disable iff (!arst_n)
    (s_r.st == ST_SUSP_WAIT && s_r.cnt != CNT_W'(SUSP_CYCLES - 1))
      |=> (s_r.st == ST_SUSP_WAIT && s_r.cnt == $past(s_r.cnt) + 1'b1))
    else $error("suspend wait counter skipped");
  AST_SUSP_DELAY: assert property (@(posedge clk) disable iff (!arst_n)
    susp_wait_done_s |=> suspend_out)
    else $error("suspend not entered after delay");
  AST_SUSP_ENTRY: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(suspend_out) |-> $past(s_r.st) == ST_SUSP_WAIT)
    else $error("suspend entered without the wait");
  AST_SUSP_STATE: assert property (@(posedge clk) disable iff (!arst_n)
    suspend_out == (s_r.st == ST_SUSP || s_r.st == ST_WAKE_WAIT))
    else $error("suspend output disagrees with state");
  AST_WAKE_FIRE: assert property (@(posedge clk) disable iff (!arst_n)
    (s_r.st == ST_SUSP) ##0 wake_rise_s |=> s_r.st == ST_WAKE_WAIT)
    else $error("wake edge did not start the wake wait");
  AST_WAKE_REFUSED: assert property (@(posedge clk) disable iff (!arst_n)
    (s_r.st != ST_SUSP && s_r.st != ST_WAKE_WAIT) |=> s_r.st != ST_WAKE_WAIT)
    else $error("wake accepted outside suspend");
  AST_WAKE_STEP: assert property (@(posedge clk) disable iff (!arst_n)
    (s_r.st == ST_WAKE_WAIT && s_r.cnt != CNT_W'(WAKE_CYCLES - 1))
      |=> (s_r.st == ST_WAKE_WAIT && s_r.cnt == $past(s_r.cnt) + 1'b1))
    else $error("wake wait counter skipped");
  AST_WAKE_DELAY: assert property (@(posedge clk) disable iff (!arst_n)
    wake_wait_done_s |=> !suspend_out)
    else $error("suspend not cleared after wake delay");
  AST_WAKE_EXIT: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(suspend_out) |-> $past(s_r.st) == ST_WAKE_WAIT)
    else $error("suspend left without the wake wait");

  // clock path checks
  AST_PLL_OFF: assert property (@(posedge clk) disable iff (!arst_n)
    suspend_out |-> !pll_running)
    else $error("pll running in suspend");
  AST_PLL_STILL: assert property (@(posedge clk) disable iff (!arst_n)
    (suspend_out && $past(suspend_out)) |-> !fast_wave)
    else $error("fast clock still toggling in suspend");
  AST_OSC_CTRL: assert property (@(posedge clk) disable iff (!arst_n)
    (!oscillator_run && !suspend_out) |=> !s_r.out_clk)
    else $error("clock out active with oscillator off");
  AST_OFF_LOW: assert property (@(posedge clk) disable iff (!arst_n)
    (!suspend_out && !$past(osc_on)) |-> !programmable_clock_out)
    else $error("clock out high after the oscillator stopped");
  AST_RUN_SRC: assert property (@(posedge clk) disable iff (!arst_n)
    !suspend_out |-> programmable_clock_out == s_r.out_clk)
    else $error("divided clock not on output while awake");
  AST_DIV_RANGE: assert property (@(posedge clk) disable iff (!arst_n)
    fast_edge |=> s_r.div_cnt <= clock_out_divider
      || $past(clock_out_divider) != clock_out_divider)
    else $error("divider count out of range");
  AST_OUT_EDGE: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(s_r.out_clk) |-> $past(fast_edge) || !$past(osc_on))
    else $error("clock out moved without a fast edge");

  // standby clock checks
  AST_STATIC: assert property (@(posedge clk) disable iff (!arst_n)
    (suspend_out && standby_clock_disable) |-> !programmable_clock_out)
    else $error("clock out toggles with standby disabled");
  AST_STANDBY: assert property (@(posedge clk) disable iff (!arst_n)
    (suspend_out && !standby_clock_disable) |-> programmable_clock_out == s_r.lz_clk)
    else $error("standby clock not on output");
  AST_STANDBY_CNT: assert property (@(posedge clk) disable iff (!arst_n)
    s_r.lz_cnt <= CNT_W'(STANDBY_HALF - 1))
    else $error("standby counter out of range");
  AST_STANDBY_EDGE: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(s_r.lz_clk) |-> $past(s_r.lz_cnt) == CNT_W'(STANDBY_HALF - 1))
    else $error("standby clock toggled off its half period");
endmodule : suspend_aware_clock_output
`default_nettype wire

// *** hdl/programmable_clock_out_pkg.sv ***
// constants for the suspend-aware clock output block
// Function
// - The fast clock is the 6 MHz reference multiplied up to 48 MHz by the internal PLL.
// - The clock output is derived from the 48 MHz clock and ranges from 3 MHz to 48 MHz.
// - In suspend both the oscillator and the PLL are stopped, so no normal clock goes out.
// - The oscillator runs or stops as the oscillator-run control bit says.
// - A four-bit division factor sets the normal clock output frequency.
// - With standby disable at zero the output keeps toggling at about 100 kHz in suspend.
// - Suspend follows a one-then-zero write of the request bit; outputs change about 2 ms on.
// - A positive wake-up pulse ends suspend; outputs return to normal after 0.5 ms.
`default_nettype none
package programmable_clock_out_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned REF_HZ = 6_000_000;
  localparam int unsigned PLL_MULT = 8;
  localparam int unsigned STANDBY_HZ = 100_000;
  localparam int unsigned SUSP_DELAY_US = 2000;
  localparam int unsigned WAKE_DELAY_US = 500;
  localparam int unsigned SUSP_CYC = SUSP_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WAKE_CYC = WAKE_DELAY_US * (CLK_HZ / 1_000_000);
  // half period of the standby clock in system cycles
  localparam int unsigned STANDBY_HALF = CLK_HZ / (2 * STANDBY_HZ);
  localparam int unsigned DIV_W = 4;
  localparam int unsigned CNT_W = 20;
  localparam logic [DIV_W-1:0] DIV_RESET = 4'h0;
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_SUSP_WAIT = 4'h2,
    ST_SUSP = 4'h4,
    ST_WAKE_WAIT = 4'h8
  } pwr_state_t;
endpackage : programmable_clock_out_pkg
`default_nettype wire

// *** hdl/clk_ratio_gen.sv ***
// fractional phase accumulator making one clock from another rate
`default_nettype none
module clk_ratio_gen #(
  parameter int unsigned ACC_W = 32
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic [ACC_W-1:0] step,
  output logic wave
);
  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic wave;
  } gen_t;
  gen_t s_r;
  gen_t s_nxt;
  always_comb begin
    s_nxt = s_r;
    if (run) begin
      {s_nxt.wave, s_nxt.acc} = {1'b0, s_r.acc} + {1'b0, step};
      s_nxt.wave = s_nxt.wave ^ s_r.wave;
    end else begin
      s_nxt.acc = '0;
      s_nxt.wave = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign wave = s_r.wave;
endmodule : clk_ratio_gen
`default_nettype wire

// *** tb/programmable_clock_out_partner.sv ***
// board-side logic that raises the wake-up pulse
`default_nettype none
module programmable_clock_out_partner (
  input wire logic clk,
  input wire logic wake_go,
  output logic device_wakeup_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // held four clocks so the two-stage synchroniser cannot miss it
  initial begin
    device_wakeup_in = 1'b0;
    forever begin
      @(posedge clk);
      if (wake_go) begin
        #1 device_wakeup_in = 1'b1;
        repeat (4) @(posedge clk);
        #1 device_wakeup_in = 1'b0;
      end
    end
  end
endmodule : programmable_clock_out_partner
`default_nettype wire

// *** tb/suspend_aware_clock_output_tb_top.sv ***
// self-checking bench for the suspend-aware clock output
`default_nettype none
module suspend_aware_clock_output_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 50;
  localparam int WC = 20;
  logic clk = 0, arst_n = 0, osc = 1, sdis = 0, req = 0, wake_go = 0;
  logic wake, cko, susp, pll;
  logic [3:0] div = 4'h0;
  int errors = 0, check_count = 0, e, t;
  always #2.5 clk = ~clk;
  suspend_aware_clock_output #(.SUSP_CYCLES(SC), .WAKE_CYCLES(WC)) uut (
    .clk(clk), .arst_n(arst_n), .oscillator_run(osc), .clock_out_divider(div),
    .standby_clock_disable(sdis), .suspend_request(req), .device_wakeup_in(wake),
    .programmable_clock_out(cko), .suspend_out(susp), .pll_running(pll));
  programmable_clock_out_partner far (.clk(clk), .wake_go(wake_go), .device_wakeup_in(wake));
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic check_bit(string name, logic exp, logic got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask : check_bit
  task automatic check_rng(string name, int lo, int hi, int got);
    check_count++;
    if (got < lo || got > hi) begin
      errors++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask : check_rng
  task automatic edges(int w, output int n);
    logic p;
    n = 0;
    p = cko;
    repeat (w) begin
      tick(1);
      if (cko === 1'b1 && p === 1'b0) n++;
      p = cko;
    end
  endtask : edges
  task automatic wait_susp(logic lvl, output int c);
    c = 0;
    while (susp !== lvl && c < 2000) begin
      tick(1);
      c++;
    end
  endtask : wait_susp
  // model from the rules: 6 MHz times 8 is 48 MHz, divided by n+1, seen over w cycles
  function automatic int model_edges(int n, int w);
    longint f;
    f = longint'(programmable_clock_out_pkg::REF_HZ) * programmable_clock_out_pkg::PLL_MULT;
    return int'(f * w / (longint'(programmable_clock_out_pkg::CLK_HZ) * (n + 1)));
  endfunction : model_edges
  function automatic int model_standby(int w);
    return int'(longint'(programmable_clock_out_pkg::STANDBY_HZ) * w / programmable_clock_out_pkg::CLK_HZ);
  endfunction : model_standby
  task automatic check_div(int n);
    int m;
    div = 4'(n);
    tick(20);
    edges(2000, e);
    m = model_edges(n, 2000);
    check_rng("clock out edges", m - 1, m + 1, e);
  endtask : check_div
  task automatic suspend_cycle(logic dis);
    int nom;
    sdis = dis;
    req = 1'b1;
    tick(3);
    req = 1'b0;
    wait_susp(1'b1, t);
    check_rng("suspend delay", SC, SC + 8, t);
    check_bit("pll in suspend", 1'b0, pll);
    edges(4000, e);
    // nominal rising edges in 20 us, with the 50 percent tolerance either side
    nom = model_standby(4000);
    if (dis) check_rng("static edges", 0, 0, e);
    else check_rng("standby edges", nom / 2, nom * 3 / 2, e);
    wake_go = 1'b1;
    tick(1);
    wake_go = 1'b0;
    wait_susp(1'b0, t);
    check_rng("wake delay", WC, WC + 8, t);
    check_bit("pll after wake", 1'b1, pll);
    check_div(int'(div));
  endtask : suspend_cycle
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // the tests need about 250 us; the limit leaves room for slow wake sequences
  initial begin
    #400000;
    errors++;
    stop_test();
  end
  initial begin
    void'($urandom(73074));
    tick(20);
    arst_n = 1'b1;
    check_bit("suspend after reset", 1'b0, susp);
    check_bit("pll after reset", 1'b1, pll);
    for (int n = 0; n < 16; n++) check_div(n);
    osc = 1'b0;
    tick(2);
    check_bit("pll stopped", 1'b0, pll);
    edges(2000, e);
    check_rng("stopped edges", 0, 0, e);
    osc = 1'b1;
    check_div(int'($urandom_range(15)));
    suspend_cycle(1'b0);
    div = 4'($urandom_range(15));
    suspend_cycle(1'b1);
    stop_test();
  end
endmodule : suspend_aware_clock_output_tb_top
`default_nettype wire
